// [src/hpc_pkg.sv]
// Package of constants and types for the hub port power control block
`default_nettype none
package hpc_pkg;
  localparam int NUM_PORTS = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Byte offsets of the configuration space
  localparam logic [7:0] OFS_SIGNATURE = 8'h00;
  localparam logic [7:0] OFS_VID_LSB = 8'h01;
  localparam logic [7:0] OFS_VID_MSB = 8'h02;
  localparam logic [7:0] OFS_PID_LSB = 8'h03;
  localparam logic [7:0] OFS_PID_MSB = 8'h04;
  localparam logic [7:0] OFS_REMOVABLE = 8'h07;
  localparam logic [7:0] OFS_PORT_USED = 8'h08;
  localparam logic [7:0] OFS_STRING_LO = 8'h20;
  localparam logic [7:0] OFS_STRING_HI = 8'hCF;
  localparam logic [7:0] OFS_STATUS_CMD = 8'hF8;
  // Field positions and values
  localparam int CFG_ACTIVE_BIT = 0;
  localparam logic [7:0] SIGNATURE_VAL = 8'h55;
  localparam logic [7:0] RST_REMOVABLE = 8'h0F;
  localparam logic [7:0] RST_PORT_USED = 8'h0F;
  localparam logic [7:0] RST_STATUS_CMD = 8'h01;
  // Cycles after reset release before straps are trusted (two sync stages, then the capture edge)
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  typedef enum logic [1:0] {
    SRC_PINS,
    SRC_EEPROM,
    SRC_SMBUS
  } hpc_src_e;
  typedef enum {
    CFG_STRAP,
    CFG_EE_SIG,
    CFG_EE_LOAD,
    CFG_SMB_WAIT,
    CFG_DONE
  } hpc_cfg_e;
endpackage
`default_nettype wire

// [src/hpc_string_mem.sv]
// Byte memory for descriptor strings with registered read data
`default_nettype none
module hpc_string_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read port
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // No reset: contents are undefined until written, so reads stay in the string region
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// [src/hpc_port_power.sv]
// Downstream port power switching and configuration policy of a four-port hub
`default_nettype none
// Operation
// - Individual mode: each port's switch follows its own host power request.
// - Individual mode: over-current removes power only from the reporting port.
// - Ganged mode: all enabled ports powered as soon as any enabled port needs power.
// - Ganged mode: power stays on until every enabled port allows removal.
// - Ganged mode: any over-current on an enabled port removes power from all ports together.
// - EEPROM loads never change the status and command register.
// - Ports disabled or permanently attached from straps, EEPROM or SMBus.
// - Vendor, product identifiers and strings replaceable by EEPROM or SMBus.
// - EEPROM byte zero must match signature, else load abandoned, defaults used.
// - SMBus mode holds upstream connect until host clears configuration-active bit.
module hpc_port_power import hpc_pkg::*; #(
  parameter int NUM_PORTS = hpc_pkg::NUM_PORTS,
  parameter logic [15:0] DEF_VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEF_PRODUCT_ID = 16'h5678 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Strap pins
  input wire logic gangStrap,
  input wire logic [1:0] cfgSrcStrap,
  input wire logic [NUM_PORTS-1:0] portDisableStrap,
  input wire logic [NUM_PORTS-1:0] portPermanentStrap,
  // Host port power requests and over-current status
  input wire logic [NUM_PORTS-1:0] portPwrReq,
  input wire logic [NUM_PORTS-1:0] ocClear,
  output logic [NUM_PORTS-1:0] ocReported,
  // External power switches and over-current sensors
  output logic [NUM_PORTS-1:0] portPwrEn,
  input wire logic [NUM_PORTS-1:0] overCurrent_n,
  // EEPROM load byte stream
  input wire logic eeStart,
  input wire logic eeValid,
  input wire logic [hpc_pkg::ADDR_W-1:0] eeAddr,
  input wire logic [hpc_pkg::DATA_W-1:0] eeData,
  input wire logic eeEnd,
  // SMBus register access
  input wire logic smbWrite,
  input wire logic smbRead,
  input wire logic [hpc_pkg::ADDR_W-1:0] smbAddr,
  input wire logic [hpc_pkg::DATA_W-1:0] smbWrData,
  output logic [hpc_pkg::DATA_W-1:0] smbRdData,
  output logic smbRdValid,
  // Resulting configuration
  output logic [15:0] vendor_identifier,
  output logic [15:0] product_identifier,
  output logic [NUM_PORTS-1:0] portDisabled,
  output logic [NUM_PORTS-1:0] portPermanent,
  output logic eeLoadAborted,
  output logic upstreamConnectEn,
  output logic gangedMode
);
  import hpc_pkg::*;

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [2:0] strapMeta_q, strapSync_q;
  logic [NUM_PORTS-1:0] ocMeta_q, ocSync_q;
  logic [2*NUM_PORTS-1:0] portStrapMeta_q, portStrapSync_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      strapMeta_q <= '0;
      strapSync_q <= '0;
      ocMeta_q <= '1;
      ocSync_q <= '1;
      portStrapMeta_q <= '0;
      portStrapSync_q <= '0;
    end else begin
      strapMeta_q <= {cfgSrcStrap, gangStrap};
      strapSync_q <= strapMeta_q;
      ocMeta_q <= overCurrent_n;
      ocSync_q <= ocMeta_q;
      portStrapMeta_q <= {portPermanentStrap, portDisableStrap};
      portStrapSync_q <= portStrapMeta_q;
    end
  end

  // ********************************
  // Strap capture after reset
  // ********************************
  logic [1:0] settle_q, settle_d;
  logic gang_q, gang_d;
  hpc_src_e src_q, src_d;

  always_comb begin
    settle_d = settle_q;
    gang_d = gang_q;
    src_d = src_q;
    if (settle_q != STRAP_SETTLE) begin
      settle_d = settle_q + 2'h1;
      if (settle_d == STRAP_SETTLE) begin
        gang_d = strapSync_q[0];
        unique case (strapSync_q[2:1])
          2'h1: src_d = SRC_EEPROM;
          2'h2: src_d = SRC_SMBUS;
          default: src_d = SRC_PINS;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      settle_q <= '0;
      gang_q <= 1'b0;
      src_q <= SRC_PINS;
    end else begin
      settle_q <= settle_d;
      gang_q <= gang_d;
      src_q <= src_d;
    end
  end

  // ********************************
  // Configuration registers and load sequence
  // ********************************
  hpc_cfg_e state_q, state_d;
  logic [15:0] vid_q, vid_d, pid_q, pid_d;
  logic [7:0] removable_q, removable_d, portUsed_q, portUsed_d, statCmd_q, statCmd_d;
  logic abort_q, abort_d;
  logic wrEn;
  logic [7:0] wrAddr, wrData;
  logic memWr, isString;

  always_comb begin
    state_d = state_q;
    abort_d = abort_q;
    wrEn = 1'b0;
    wrAddr = smbAddr;
    wrData = smbWrData;
    unique case (state_q)
      CFG_STRAP: begin
        if (settle_q == STRAP_SETTLE) begin
          unique case (src_q)
            SRC_EEPROM: state_d = CFG_EE_SIG;
            SRC_SMBUS: state_d = CFG_SMB_WAIT;
            default: state_d = CFG_DONE;
          endcase
        end
      end
      CFG_EE_SIG: begin
        wrAddr = eeAddr;
        wrData = eeData;
        if (eeValid && eeAddr == OFS_SIGNATURE) begin
          if (eeData == SIGNATURE_VAL) begin
            state_d = CFG_EE_LOAD;
          end else begin
            abort_d = 1'b1;
            state_d = CFG_DONE;
          end
        end else if (eeEnd) begin
          abort_d = 1'b1;
          state_d = CFG_DONE;
        end
      end
      CFG_EE_LOAD: begin
        wrAddr = eeAddr;
        wrData = eeData;
        wrEn = eeValid && eeAddr != OFS_STATUS_CMD;
        if (eeEnd) begin
          state_d = CFG_DONE;
        end
      end
      CFG_SMB_WAIT: begin
        wrEn = smbWrite;
        if (!statCmd_q[CFG_ACTIVE_BIT]) begin
          state_d = CFG_DONE;
        end
      end
      CFG_DONE: begin
        wrEn = smbWrite && src_q == SRC_SMBUS;
        if (eeStart && src_q == SRC_EEPROM) begin
          abort_d = 1'b0;
          state_d = CFG_EE_SIG;
        end
      end
    endcase
  end

  always_comb begin
    vid_d = vid_q;
    pid_d = pid_q;
    removable_d = removable_q;
    portUsed_d = portUsed_q;
    statCmd_d = statCmd_q;
    if (wrEn) begin
      unique case (wrAddr)
        OFS_VID_LSB: vid_d[7:0] = wrData;
        OFS_VID_MSB: vid_d[15:8] = wrData;
        OFS_PID_LSB: pid_d[7:0] = wrData;
        OFS_PID_MSB: pid_d[15:8] = wrData;
        OFS_REMOVABLE: removable_d = wrData;
        OFS_PORT_USED: portUsed_d = wrData;
        OFS_STATUS_CMD: statCmd_d[CFG_ACTIVE_BIT] = wrData[CFG_ACTIVE_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= CFG_STRAP;
      abort_q <= 1'b0;
      vid_q <= DEF_VENDOR_ID;
      pid_q <= DEF_PRODUCT_ID;
      removable_q <= RST_REMOVABLE;
      portUsed_q <= RST_PORT_USED;
      statCmd_q <= RST_STATUS_CMD;
    end else begin
      state_q <= state_d;
      abort_q <= abort_d;
      vid_q <= vid_d;
      pid_q <= pid_d;
      removable_q <= removable_d;
      portUsed_q <= portUsed_d;
      statCmd_q <= statCmd_d;
    end
  end

  // Strings are bulky, so they sit in memory instead of resettable flops
  assign isString = smbAddr >= OFS_STRING_LO && smbAddr <= OFS_STRING_HI;
  assign memWr = wrEn && wrAddr >= OFS_STRING_LO && wrAddr <= OFS_STRING_HI;

  logic [7:0] memRdData;
  hpc_string_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) uStrings (
    .mclk(mclk),
    .wrEn(memWr),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(smbAddr),
    .rdData(memRdData)
  );

  // ********************************
  // SMBus read path
  // ********************************
  logic rdPend_q, rdPend_d, rdStr_q, rdStr_d;
  logic [7:0] rdReg_q, rdReg_d;

  always_comb begin
    rdPend_d = smbRead && src_q == SRC_SMBUS;
    rdStr_d = isString;
    unique case (smbAddr)
      OFS_SIGNATURE: rdReg_d = SIGNATURE_VAL;
      OFS_VID_LSB: rdReg_d = vid_q[7:0];
      OFS_VID_MSB: rdReg_d = vid_q[15:8];
      OFS_PID_LSB: rdReg_d = pid_q[7:0];
      OFS_PID_MSB: rdReg_d = pid_q[15:8];
      OFS_REMOVABLE: rdReg_d = removable_q;
      OFS_PORT_USED: rdReg_d = portUsed_q;
      OFS_STATUS_CMD: rdReg_d = statCmd_q;
      default: rdReg_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdPend_q <= 1'b0;
      rdStr_q <= 1'b0;
      rdReg_q <= 8'h00;
    end else begin
      rdPend_q <= rdPend_d;
      rdStr_q <= rdStr_d;
      rdReg_q <= rdReg_d;
    end
  end

  assign smbRdValid = rdPend_q;
  assign smbRdData = rdStr_q ? memRdData : rdReg_q;

  // ********************************
  // Port power switching
  // ********************************
  logic [NUM_PORTS-1:0] pwr_q, pwr_d, ocLatch_q, ocLatch_d, ocRep_q, ocRep_d;
  logic [NUM_PORTS-1:0] disabledNow, ocNow;
  logic gangOn_q, gangOn_d, gangOc_q, gangOc_d;

  assign ocNow = ~ocSync_q;
  assign disabledNow = (src_q == SRC_PINS) ? portStrapSync_q[NUM_PORTS-1:0]
                                           : ~portUsed_q[NUM_PORTS-1:0];

  always_comb begin
    gangOn_d = gangOn_q;
    gangOc_d = gangOc_q;
    if (|(ocNow & ~disabledNow) && gangOn_q) begin
      gangOc_d = 1'b1;
      gangOn_d = 1'b0;
    end else if (|(portPwrReq & ~disabledNow)) begin
      gangOn_d = !gangOc_q;
    end else begin
      gangOn_d = 1'b0;
      gangOc_d = 1'b0;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : gPort
      always_comb begin
        ocLatch_d[p] = ocLatch_q[p];
        if (ocNow[p] && pwr_q[p]) begin
          ocLatch_d[p] = 1'b1;
        end else if (!portPwrReq[p]) begin
          ocLatch_d[p] = 1'b0;
        end
        if (gang_q) begin
          pwr_d[p] = gangOn_d && !disabledNow[p];
        end else begin
          pwr_d[p] = portPwrReq[p] && !disabledNow[p] && !ocLatch_d[p];
        end
        // A new over-current wins over a clear in the same cycle
        ocRep_d[p] = (ocRep_q[p] && !ocClear[p]) || (ocNow[p] && pwr_q[p]);
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pwr_q <= '0;
      ocLatch_q <= '0;
      ocRep_q <= '0;
      gangOn_q <= 1'b0;
      gangOc_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      ocLatch_q <= ocLatch_d;
      ocRep_q <= ocRep_d;
      gangOn_q <= gangOn_d;
      gangOc_q <= gangOc_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign portPwrEn = pwr_q;
  assign ocReported = ocRep_q;
  assign vendor_identifier = vid_q;
  assign product_identifier = pid_q;
  assign portDisabled = disabledNow;
  assign portPermanent = (src_q == SRC_PINS) ? portStrapSync_q[2*NUM_PORTS-1:NUM_PORTS]
                                             : ~removable_q[NUM_PORTS-1:0];
  assign eeLoadAborted = abort_q;
  assign upstreamConnectEn = state_q == CFG_DONE;
  assign gangedMode = gang_q;
endmodule
`default_nettype wire

// [bench/hpc_port_power_assertions.sv]
// Concurrent checks on the ports of the port power block
`default_nettype none
module hpc_port_power_assertions import hpc_pkg::*; #(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Power
  input wire logic [NUM_PORTS-1:0] portPwrReq,
  input wire logic [NUM_PORTS-1:0] ocReported,
  input wire logic [NUM_PORTS-1:0] portPwrEn,
  input wire logic [NUM_PORTS-1:0] overCurrent_n,
  input wire logic [NUM_PORTS-1:0] portDisabled,
  input wire logic gangedMode,
  // Configuration
  input wire logic eeValid,
  input wire logic [hpc_pkg::ADDR_W-1:0] eeAddr,
  input wire logic [hpc_pkg::DATA_W-1:0] eeData,
  input wire logic smbWrite,
  input wire logic [hpc_pkg::ADDR_W-1:0] smbAddr,
  input wire logic [hpc_pkg::DATA_W-1:0] smbWrData,
  input wire logic eeLoadAborted,
  input wire logic upstreamConnectEn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_indiv_req;
    !gangedMode |-> (portPwrEn & ~$past(portPwrReq)) == '0;
  endproperty
  a_indiv_req: assert property (p_indiv_req) else $error("unrequested power");
  property p_indiv_oc;
    !gangedMode |-> ($past(portPwrEn & portPwrReq) & portPwrReq & ~portPwrEn & ~ocReported) == '0;
  endproperty
  a_indiv_oc: assert property (p_indiv_oc) else $error("port lost power");
  property p_oc_off;
    (~overCurrent_n & portPwrEn) != '0 |-> ##[1:3] (~overCurrent_n & portPwrEn) == '0;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overload kept");
  property p_gang_all;
    gangedMode |-> portPwrEn == '0 || (portPwrEn | portDisabled) == '1;
  endproperty
  a_gang_all: assert property (p_gang_all) else $error("gang split");
  property p_gang_hold;
    gangedMode && portPwrEn != '0 && (portPwrReq & ~portDisabled) != '0 && &overCurrent_n
      |=> portPwrEn != '0;
  endproperty
  a_gang_hold: assert property (p_gang_hold) else $error("gang dropped");
  property p_mode_fixed;
    upstreamConnectEn |=> $stable(gangedMode);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode moved");
  property p_smb_done;
    smbWrite && smbAddr == OFS_STATUS_CMD && !smbWrData[CFG_ACTIVE_BIT] && !upstreamConnectEn
      |-> ##2 upstreamConnectEn;
  endproperty
  a_smb_done: assert property (p_smb_done) else $error("no connect");
  property p_ee_sig;
    eeValid && eeAddr == OFS_SIGNATURE && eeData != SIGNATURE_VAL |=> eeLoadAborted;
  endproperty
  a_ee_sig: assert property (p_ee_sig) else $error("bad signature kept");
  c_gang: cover property (gangedMode && $fell(|portPwrEn));
  c_indiv: cover property (!gangedMode && ocReported != '0);
  c_abort: cover property ($rose(eeLoadAborted));
endmodule
bind hpc_port_power hpc_port_power_assertions #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .mclk, .nrst, .portPwrReq, .ocReported, .portPwrEn, .overCurrent_n, .portDisabled,
  .gangedMode, .eeValid, .eeAddr, .eeData, .smbWrite, .smbAddr, .smbWrData,
  .eeLoadAborted, .upstreamConnectEn
);
`default_nettype wire

// [bench/hpc_switch_model.sv]
// Port power switches with over-current sensors
`default_nettype none
module hpc_switch_model #(
  parameter int NUM_PORTS = 4
) (
  // Switch enables
  input wire logic [NUM_PORTS-1:0] portPwrEn,
  // Overloaded loads
  input wire logic [NUM_PORTS-1:0] fault,
  // Open-drain flags, pulled up
  output logic [NUM_PORTS-1:0] overCurrent_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only a live overloaded switch trips
  assign overCurrent_n = ~(portPwrEn & fault);
endmodule
`default_nettype wire

// [bench/hpc_port_power_test.sv]
// Self-checking bench of the port power block
`default_nettype none
module hpc_port_power_test;
  timeunit 1ns;
  timeprecision 1ns;
  import hpc_pkg::*;
  typedef struct packed {logic g; logic [3:0] req; logic [3:0] pwr;} hpc_row_s;
  logic mclk, nrst, gangStrap, eeStart, eeValid, eeEnd, smbWrite, smbRead, smbRdValid;
  logic eeLoadAborted, upstreamConnectEn, gangedMode;
  logic [1:0] cfgSrcStrap;
  logic [3:0] portDisableStrap, portPermanentStrap, portPwrReq, ocClear, ocReported;
  logic [3:0] portPwrEn, overCurrent_n, fault, portDisabled, portPermanent;
  logic [7:0] eeAddr, eeData, smbAddr, smbWrData, smbRdData;
  logic [15:0] vendor_identifier, product_identifier;
  int mismatches = 0;
  int checks_done = 0;
  // Mode, request, expected power
  hpc_row_s rows [9] = '{9'h011, 9'h055, 9'h0AA, 9'h0FF, 9'h000, 9'h11F, 9'h13F, 9'h12F,
    9'h100};
  hpc_port_power uut (
    .mclk, .nrst, .gangStrap, .cfgSrcStrap, .portDisableStrap, .portPermanentStrap,
    .portPwrReq, .ocClear, .ocReported, .portPwrEn, .overCurrent_n, .eeStart, .eeValid,
    .eeAddr, .eeData, .eeEnd, .smbWrite, .smbRead, .smbAddr, .smbWrData, .smbRdData,
    .smbRdValid, .vendor_identifier, .product_identifier, .portDisabled, .portPermanent,
    .eeLoadAborted, .upstreamConnectEn, .gangedMode
  );
  hpc_switch_model sw (.portPwrEn, .fault, .overCurrent_n);
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rst(input logic g, input logic [1:0] src);
    nrst = 0;
    {gangStrap, cfgSrcStrap} = {g, src};
    {eeStart, eeValid, eeEnd, smbWrite, smbRead, eeAddr, eeData, smbAddr, smbWrData} = '0;
    {portDisableStrap, portPermanentStrap, portPwrReq, ocClear, fault} = '0;
    step(3);
    nrst = 1;
    step(5);
  endtask
  task automatic smbW(input logic [7:0] a, input logic [7:0] d);
    {smbWrite, smbAddr, smbWrData} = {1'h1, a, d};
    step(1);
    smbWrite = 0;
    step(1);
  endtask
  task automatic smbR(input logic [7:0] a, input logic [7:0] d);
    {smbRead, smbAddr} = {1'h1, a};
    step(1);
    smbRead = 0;
    chk("rdvalid", smbRdValid, 1'h1);
    chk("rddata", smbRdData, d);
    step(1);
  endtask
  // Bytes stream back to back
  task automatic ee(input logic [7:0] a, input logic [7:0] d);
    {eeValid, eeAddr, eeData} = {1'h1, a, d};
    step(1);
  endtask
  task automatic run(input logic g);
    foreach (rows[i]) begin
      if (rows[i].g === g) begin
        portPwrReq = rows[i].req;
        step(1);
        chk("power", portPwrEn, rows[i].pwr);
      end
    end
  endtask
  initial begin
    repeat (1000) @(posedge mclk);
    mismatches++;
    test_done();
  end
  initial begin
    rst(1'h0, 2'h2);
    chk("connect", upstreamConnectEn, 1'h0);
    chk("vendor", vendor_identifier, 16'h1234);
    chk("product", product_identifier, 16'h5678);
    smbW(OFS_VID_LSB, 8'hCD);
    smbW(OFS_VID_MSB, 8'hAB);
    smbW(OFS_REMOVABLE, 8'h0C);
    chk("vendor", vendor_identifier, 16'hABCD);
    chk("permanent", portPermanent, 4'h3);
    chk("connect", upstreamConnectEn, 1'h0);
    smbW(OFS_STATUS_CMD, 8'h00);
    chk("connect", upstreamConnectEn, 1'h1);
    smbR(OFS_SIGNATURE, SIGNATURE_VAL);
    smbR(OFS_STATUS_CMD, 8'h00);
    smbR(8'h10, 8'h00);
    // String bytes come back through the memory path
    smbW(8'h30, 8'h5A);
    smbR(8'h30, 8'h5A);
    run(1'h0);
    portPwrReq = 4'hF;
    step(1);
    fault = 4'h4;
    step(2);
    // Clear lands on the setting edge: the new event must win
    ocClear = 4'h4;
    step(1);
    chk("power", portPwrEn, 4'hB);
    chk("overcur", ocReported, 4'h4);
    {fault, ocClear} = {4'h0, 4'h4};
    step(1);
    ocClear = 0;
    chk("overcur", ocReported, 4'h0);
    portPwrReq = 0;
    smbW(OFS_PORT_USED, 8'h0E);
    chk("disabled", portDisabled, 4'h1);
    portPwrReq = 4'hF;
    step(1);
    chk("power", portPwrEn, 4'hE);
    rst(1'h1, 2'h1);
    chk("ganged", gangedMode, 1'h1);
    ee(OFS_SIGNATURE, 8'hAA);
    eeValid = 0;
    chk("aborted", eeLoadAborted, 1'h1);
    chk("vendor", vendor_identifier, 16'h1234);
    eeStart = 1;
    step(1);
    eeStart = 0;
    ee(OFS_SIGNATURE, SIGNATURE_VAL);
    ee(OFS_VID_LSB, 8'h11);
    ee(OFS_VID_MSB, 8'h22);
    ee(OFS_PID_LSB, 8'h33);
    ee(OFS_STATUS_CMD, 8'h00);
    {eeValid, eeEnd} = 2'h1;
    step(1);
    eeEnd = 0;
    step(1);
    chk("vendor", vendor_identifier, 16'h2211);
    chk("product", product_identifier, 16'h5633);
    run(1'h1);
    portPwrReq = 4'h1;
    step(1);
    fault = 4'h8;
    step(3);
    chk("power", portPwrEn, 4'h0);
    {fault, gangStrap, portPwrReq} = '0;
    step(1);
    portPwrReq = 4'h2;
    step(4);
    chk("power", portPwrEn, 4'hF);
    chk("ganged", gangedMode, 1'h1);
    // Pin mode: attributes follow the straps, connect without host
    rst(1'h0, 2'h0);
    chk("ganged", gangedMode, 1'h0);
    {portDisableStrap, portPermanentStrap, portPwrReq} = {4'h2, 4'h8, 4'hF};
    step(2);
    chk("connect", upstreamConnectEn, 1'h1);
    chk("disabled", portDisabled, 4'h2);
    chk("permanent", portPermanent, 4'h8);
    step(1);
    chk("power", portPwrEn, 4'hD);
    test_done();
  end
endmodule
`default_nettype wire
